// ===== hdl/dss_top.sv
// What this block does
// - Host write 0100h to 6Fh launches step 0
// - Whole program runs in roughly 446.5 ms
// - Step 0 sets bias field, waits 0.5625 ms
// - Discharge speaker, enable speakers, end discharge
// - Step 4 writes reference control byte F7h
// - Speakers off, ramp cleared, resistor 01b, bias on
// - Enable gain stages, mixers, line, DSP clock
// - Step 13 enables both converters, waits 2.5 ms
// - Dummy steps to FFh change no register
// - Step 15 clears output bias control bit
// - Step 16 enables charge pump, waits 4.5 ms
// - Output enables, then delayed enables, whole bytes
// - Servo mode, then servo enables with long waits
// - Steps 26-27 enable output drive stages
// - Shorts removed; step 29 ends the program
// - Steps 30-31 are unused dummy writes
// - Step lasts 62.5 us times (2^code + 8)
// - Low data bits placed at field start
`include "dss_params.svh"

module dss_top
    import dss_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `DSS_TICK_CYCLES
)(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // Host control write
    input  wire logic        HOST_WR,
    input  wire logic [7:0]  HOST_ADDR,
    input  wire logic [15:0] HOST_DATA,
    // Control register file access
    output logic             REG_RD,
    output logic             REG_WR,
    output logic [7:0]       REG_ADDR,
    output logic [15:0]      REG_WDATA,
    input  wire logic [15:0] REG_RDATA,
    // Status
    output logic             BUSY,
    output logic [4:0]       STEP,
    output logic             DONE
);

    // ********************************************************
    // Declarations
    // ********************************************************
    dss_step_if    stp ();          // Table lookup carrier
    dss_state_type state_r;         // Sequencer state
    dss_step_type  step_r;          // Step being executed
    logic [15:0]   mask_r;          // Field mask of this step
    logic [15:0]   bits_r;          // Placed field data
    logic [4:0]    index_r;         // Current step index
    logic [15:0]   cyc_r;           // Cycles within one tick
    logic [16:0]   tick_r;          // Ticks within one step
    logic [16:0]   ticks_need;      // Ticks this step lasts
    logic          launch;          // Start request seen
    logic          tick_end;        // Last cycle of a tick
    logic          step_end;        // Last cycle of a step
    logic          dummy;           // Step targets no register
    logic          reg_rd_r;        // Read strobe
    logic          reg_wr_r;        // Write strobe
    logic [7:0]    reg_addr_r;      // Target address
    logic [15:0]   reg_wdata_r;     // Merged write data
    logic          busy_r;          // Program running
    logic          done_r;          // Program finished pulse
    logic [31:0]   len_r;           // Step length, checks only
    logic [15:0]   rdata_r;         // Read value, checks only

    // ********************************************************
    // Step table
    // ********************************************************
    assign stp.index = index_r;

    dss_rom u_rom (
        .s (stp)
    );

    // ********************************************************
    // Launch decode and step timing
    // ********************************************************

    // Only the exact launch value counts; others are ignored
    assign launch = HOST_WR && (HOST_ADDR == `DSS_LAUNCH_ADDR) &&
                    (HOST_DATA == `DSS_LAUNCH_VALUE);

    // Step time in ticks: 2^code + 8
    assign ticks_need = (17'h00001 << step_r.delay) +
                        `DSS_DELAY_BASE;
    assign tick_end   = (cyc_r == 16'(TICK_CYCLES - 1));
    assign step_end   = tick_end && (tick_r == ticks_need - 17'h00001);
    assign dummy      = (step_r.addr == `DSS_DUMMY_ADDR);

    // ********************************************************
    // Sequencer state
    // ********************************************************

    // Launch while running is ignored, so a run is never cut
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_r <= DSS_IDLE;
        end else begin
            case (state_r)
                // Wait for the host to launch
                DSS_IDLE: begin
                    if (launch) begin
                        state_r <= DSS_FETCH;
                    end
                end
                // Address presented, read pending
                DSS_FETCH: begin
                    state_r <= DSS_MERGE;
                end
                // Read data in, write issued
                DSS_MERGE: begin
                    state_r <= DSS_WAIT;
                end
                // Hold until the step time is used up
                DSS_WAIT: begin
                    if (step_end && step_r.eos) begin
                        state_r <= DSS_IDLE;
                    end else if (step_end) begin
                        state_r <= DSS_FETCH;
                    end
                end
                default: begin
                    state_r <= DSS_IDLE;
                end
            endcase
        end
    end

    // Step index: zero at launch, then strictly in order
    always_ff @(posedge CLK) begin
        if (RST) begin
            index_r <= `DSS_FIRST_STEP;
        end else if (state_r == DSS_IDLE && launch) begin
            index_r <= `DSS_FIRST_STEP;
        end else if (state_r == DSS_WAIT && step_end && !step_r.eos) begin
            index_r <= index_r + 5'h01;
        end
    end

    // Latch the table row so the lookup may move on freely
    always_ff @(posedge CLK) begin
        if (RST) begin
            step_r <= '0;
            mask_r <= 16'h0000;
            bits_r <= 16'h0000;
        end else if (state_r == DSS_FETCH) begin
            step_r <= stp.step;
            mask_r <= stp.mask;
            bits_r <= stp.bits;
        end
    end

    // Tick and cycle counters run from the step's first cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            cyc_r  <= 16'h0000;
            tick_r <= 17'h00000;
        end else if (state_r == DSS_IDLE || step_end) begin
            cyc_r  <= 16'h0000;
            tick_r <= 17'h00000;
        end else if (tick_end) begin
            cyc_r  <= 16'h0000;
            tick_r <= tick_r + 17'h00001;
        end else begin
            cyc_r  <= cyc_r + 16'h0001;
        end
    end

    // ********************************************************
    // Register file access
    // ********************************************************

    // Read then write; a dummy step still costs its full time
    always_ff @(posedge CLK) begin
        if (RST) begin
            reg_rd_r   <= 1'b0;
            reg_addr_r <= 8'h00;
        end else if (state_r == DSS_FETCH) begin
            reg_rd_r   <= (stp.step.addr != `DSS_DUMMY_ADDR);
            reg_addr_r <= stp.step.addr;
        end else begin
            reg_rd_r   <= 1'b0;
        end
    end

    // Merge keeps every bit outside the field as read
    always_ff @(posedge CLK) begin
        if (RST) begin
            reg_wr_r    <= 1'b0;
            reg_wdata_r <= 16'h0000;
        end else if (state_r == DSS_MERGE) begin
            reg_wr_r    <= !dummy;
            reg_wdata_r <= (REG_RDATA & ~mask_r) | bits_r;
        end else begin
            reg_wr_r    <= 1'b0;
        end
    end

    // ********************************************************
    // Status
    // ********************************************************

    // Busy from launch to the end of the flagged step
    always_ff @(posedge CLK) begin
        if (RST) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= (state_r == DSS_WAIT) && step_end && step_r.eos;
            if (state_r == DSS_IDLE && launch) begin
                busy_r <= 1'b1;
            end else if (state_r == DSS_WAIT && step_end && step_r.eos) begin
                busy_r <= 1'b0;
            end
        end
    end

    assign REG_RD    = reg_rd_r;
    assign REG_WR    = reg_wr_r;
    assign REG_ADDR  = reg_addr_r;
    assign REG_WDATA = reg_wdata_r;
    assign BUSY      = busy_r;
    assign STEP      = index_r;
    assign DONE      = done_r;

    // ********************************************************
    // Checks
    // ********************************************************

    // Helper: cycles since the step began, and read data held
    always_ff @(posedge CLK) begin
        if (RST || state_r == DSS_IDLE || step_end) begin
            len_r <= 32'h00000000;
        end else begin
            len_r <= len_r + 32'h00000001;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_r <= 16'h0000;
        end else if (state_r == DSS_MERGE) begin
            rdata_r <= REG_RDATA;
        end
    end

    a_launch_starts: assert property (
        @(posedge CLK) disable iff (RST)
        (state_r == DSS_IDLE && launch) |=>
            (BUSY && STEP == 5'h00 && state_r == DSS_FETCH) ##1 REG_RD)
        else $error("launch did not start step zero");

    // A relaunch restarts at zero, so only moves within one run count
    a_step_order: assert property (
        @(posedge CLK) disable iff (RST)
        (BUSY && $past(BUSY) && $changed(STEP)) |->
            (STEP == $past(STEP) + 5'h01))
        else $error("step index skipped");

    a_step_length: assert property (
        @(posedge CLK) disable iff (RST)
        (state_r == DSS_WAIT && step_end) |->
            (len_r == 32'(TICK_CYCLES) * 32'(ticks_need) - 32'h00000001))
        else $error("step length wrong");

    a_write_follows: assert property (
        @(posedge CLK) disable iff (RST)
        REG_RD |=> REG_WR && $stable(REG_ADDR))
        else $error("read not followed by write");

    a_field_only: assert property (
        @(posedge CLK) disable iff (RST)
        REG_WR |-> ((REG_WDATA & ~mask_r) == (rdata_r & ~mask_r)) &&
                   ((REG_WDATA & mask_r) == bits_r))
        else $error("bits outside the field changed");

    a_dummy_quiet: assert property (
        @(posedge CLK) disable iff (RST)
        (REG_ADDR == `DSS_DUMMY_ADDR) |-> !REG_WR && !REG_RD)
        else $error("dummy step touched a register");

    a_end_stops: assert property (
        @(posedge CLK) disable iff (RST)
        (state_r == DSS_WAIT && step_end && step_r.eos) |=>
            DONE && !BUSY && STEP == 5'h1D ##1 !DONE)
        else $error("program did not stop at end flag");

    a_first_step: assert property (
        @(posedge CLK) disable iff (RST)
        (REG_WR && STEP == 5'h00) |->
            (REG_ADDR == 8'h04 && mask_r == 16'h001F &&
             bits_r == 16'h001A))
        else $error("first step wrote wrong field");

    a_idle_quiet: assert property (
        @(posedge CLK) disable iff (RST)
        (!BUSY && !(state_r == DSS_IDLE && launch)) |=> !REG_RD)
        else $error("access without a launch");

    // Spare rows stay unreached while the end flag sits at step 29
    a_spare_unused: assert property (
        @(posedge CLK) disable iff (RST)
        BUSY |-> (STEP <= 5'h1D))
        else $error("spare step reached");

endmodule

// ===== hdl/dss_params.svh
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH

// ************************************************************
// Control addresses and launch value
// ************************************************************
`define DSS_LAUNCH_ADDR    8'h6F
`define DSS_LAUNCH_VALUE   16'h0100
`define DSS_DUMMY_ADDR     8'hFF

// ************************************************************
// Step layout and timing
// ************************************************************
`define DSS_FIRST_STEP     5'h00
`define DSS_DELAY_BASE     17'h00008
`define DSS_TICK_NS        62500
`define DSS_CLK_NS         50
`define DSS_TICK_CYCLES    (`DSS_TICK_NS / `DSS_CLK_NS)

`endif

// ===== hdl/dss_pkg.sv
// ************************************************************
// Types shared by the start-up sequencer
// ************************************************************
package dss_pkg;

    // Sequencer control states
    typedef enum logic [1:0] {
        DSS_IDLE  = 2'b00,
        DSS_FETCH = 2'b01,
        DSS_MERGE = 2'b10,
        DSS_WAIT  = 2'b11
    } dss_state_type;

    // One program step as held in the table
    typedef struct packed {
        logic [7:0] addr;   // Target control address
        logic [2:0] wcode;  // Field width minus one
        logic [3:0] lsb;    // Field start bit
        logic [7:0] data;   // Field value, low bits used
        logic [3:0] delay;  // Coded delay after the step
        logic       eos;    // Stop after this step
    } dss_step_type;

endpackage

// ===== hdl/dss_step_if.sv
// ************************************************************
// Carrier between the sequencer and its step table
// ************************************************************
interface dss_step_if;
    import dss_pkg::*;

    logic [4:0]   index;  // Step being looked up
    dss_step_type step;   // Decoded step fields
    logic [15:0]  mask;   // Bits of the target field
    logic [15:0]  bits;   // Field data at its position

    modport seq (output index, input step, input mask, input bits);
    modport rom (input index, output step, output mask, output bits);
endinterface

// ===== hdl/dss_rom.sv
// ************************************************************
// Default program table and field placement
// ************************************************************
`include "dss_params.svh"

module dss_rom
    import dss_pkg::*;
(
    // Lookup side
    dss_step_if.rom s
);

    // Packs one table row
    function automatic dss_step_type mk(input logic [7:0] a,
                                        input logic [2:0] w,
                                        input logic [3:0] l,
                                        input logic [7:0] d,
                                        input logic [3:0] t,
                                        input logic       e);
        mk = '{addr: a, wcode: w, lsb: l, data: d, delay: t, eos: e};
    endfunction

    // Power-up program, spare rows are harmless dummy writes
    always_comb begin
        case (s.index)
            5'h00: s.step = mk(8'h04, 3'h4, 4'h0, 8'h1A, 4'h0, 1'b0);
            5'h01: s.step = mk(8'h41, 3'h0, 4'h1, 8'h01, 4'h9, 1'b0);
            5'h02: s.step = mk(8'h11, 3'h1, 4'h0, 8'h03, 4'h0, 1'b0);
            5'h03: s.step = mk(8'h41, 3'h0, 4'h1, 8'h00, 4'h0, 1'b0);
            5'h04: s.step = mk(8'h05, 3'h7, 4'h0, 8'hF7, 4'hB, 1'b0);
            5'h05: s.step = mk(8'h11, 3'h1, 4'h0, 8'h00, 4'h0, 1'b0);
            5'h06: s.step = mk(8'h05, 3'h1, 4'h3, 8'h00, 4'h0, 1'b0);
            5'h07: s.step = mk(8'h05, 3'h1, 4'h1, 8'h01, 4'h0, 1'b0);
            5'h08: s.step = mk(8'h04, 3'h0, 4'h0, 8'h01, 4'h0, 1'b0);
            5'h09: s.step = mk(8'h0E, 3'h1, 4'h0, 8'h03, 4'h0, 1'b0);
            5'h0A: s.step = mk(8'h0D, 3'h1, 4'h0, 8'h03, 4'h0, 1'b0);
            5'h0B: s.step = mk(8'h0F, 3'h1, 4'h0, 8'h03, 4'h0, 1'b0);
            5'h0C: s.step = mk(8'h16, 3'h0, 4'h1, 8'h01, 4'h0, 1'b0);
            5'h0D: s.step = mk(8'h12, 3'h1, 4'h2, 8'h03, 4'h5, 1'b0);
            5'h0F: s.step = mk(8'h04, 3'h0, 4'h4, 8'h00, 4'h0, 1'b0);
            5'h10: s.step = mk(8'h62, 3'h0, 4'h0, 8'h01, 4'h6, 1'b0);
            5'h12: s.step = mk(8'h5A, 3'h7, 4'h0, 8'h11, 4'h0, 1'b0);
            5'h13: s.step = mk(8'h5E, 3'h7, 4'h0, 8'h11, 4'h0, 1'b0);
            5'h14: s.step = mk(8'h5A, 3'h7, 4'h0, 8'h33, 4'h0, 1'b0);
            5'h15: s.step = mk(8'h5E, 3'h7, 4'h0, 8'h33, 4'h0, 1'b0);
            5'h16: s.step = mk(8'h45, 3'h1, 4'h0, 8'h02, 4'h0, 1'b0);
            5'h17: s.step = mk(8'h43, 3'h3, 4'h0, 8'h0F, 4'hC, 1'b0);
            5'h18: s.step = mk(8'h43, 3'h3, 4'h0, 8'h0F, 4'h7, 1'b0);
            5'h1A: s.step = mk(8'h5A, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0);
            5'h1B: s.step = mk(8'h5E, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0);
            5'h1C: s.step = mk(8'h5A, 3'h7, 4'h0, 8'hFF, 4'h0, 1'b0);
            5'h1D: s.step = mk(8'h5E, 3'h7, 4'h0, 8'hFF, 4'h0, 1'b1);
            // Rows 0Eh, 11h, 19h, 1Eh, 1Fh: dummy writes
            default: s.step = mk(`DSS_DUMMY_ADDR, 3'h0, 4'h0, 8'h00,
                                 4'h0, 1'b0);
        endcase
    end

    // Per bit: in field when lsb <= i <= lsb + width - 1
    for (genvar i = 0; i < 16; i++) begin : g_bit
        logic [4:0] rel;  // Offset of bit i inside the field
        logic       hit;  // Bit i belongs to the field
        assign rel = 5'(i) - {1'b0, s.step.lsb};
        assign hit = (5'(i) >= {1'b0, s.step.lsb}) &&
                     (rel <= {2'b00, s.step.wcode});
        assign s.mask[i] = hit;
        // Upper data bits beyond the width are never used
        assign s.bits[i] = hit & s.step.data[rel[2:0]];
    end

endmodule

// ===== tb/dss_regfile_model.sv
// ************************************************************
// Control register file seen by the start-up sequencer
// ************************************************************
module dss_regfile_model (
    // Clock
    input  wire logic        clk,
    // Register access from the sequencer
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] mem [256];  // Register contents

    // Non-zero start pattern so that untouched bits are visible
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = {8'(i), 8'(i) ^ 8'hA5};
        end
    end

    // Read data only valid while the read strobe stands; otherwise
    // the inverse is shown so a late sample cannot pass by luck
    assign reg_rdata = reg_rd ? mem[reg_addr] : ~mem[reg_addr];

    // Writes land on the rising edge; no register lives at FFh
    always @(posedge clk) begin
        if (reg_wr && reg_addr != 8'hFF) begin
            mem[reg_addr] <= reg_wdata;
        end
    end
endmodule

// ===== tb/tb_dss_top.sv
// ************************************************************
// Self-checking bench for the start-up sequencer
// ************************************************************
module tb_dss_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TICK = 4;  // Short tick keeps the run small

    typedef struct {
        logic [7:0] addr;  // Target address
        int         w;     // Field width
        int         lsb;   // Field start bit
        logic [7:0] data;  // Field value
        int         dly;   // Delay code
    } dss_row_type;

    logic        clk;        // Master clock
    logic        rst;        // Synchronous reset
    logic        host_wr;    // Host write strobe
    logic [7:0]  host_addr;  // Host write address
    logic [15:0] host_data;  // Host write data
    logic        reg_rd;     // Read strobe seen
    logic        reg_wr;     // Write strobe seen
    logic [7:0]  reg_addr;   // Target address seen
    logic [15:0] reg_wdata;  // Merged write value seen
    logic [15:0] reg_rdata;  // Register file answer
    logic        busy;       // Program running
    logic [4:0]  step;       // Current step
    logic        done;       // Finish pulse
    int          err_count;  // Mismatches
    int          comparisons;  // Checks made
    int          cyc;        // Cycle counter
    logic [15:0] shadow [256];  // Expected register contents
    dss_row_type rows [30];  // Default program, steps 0 to 29

    dss_top #(.TICK_CYCLES(TICK)) dut (
        .CLK(clk), .RST(rst), .HOST_WR(host_wr), .HOST_ADDR(host_addr),
        .HOST_DATA(host_data), .REG_RD(reg_rd), .REG_WR(reg_wr),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .BUSY(busy), .STEP(step), .DONE(done));

    dss_regfile_model rf (
        .clk(clk), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // Free-running clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Cycle count for step lengths
    always @(posedge clk) cyc++;

    // Single-bit compare
    task automatic chk_bit(string name, logic exp, logic got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    // Word compare, narrower values zero-extended
    task automatic chk_word(string name, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Cycle count compare
    task automatic chk_count(string name, int exp, int got);
        comparisons++;
        if (got != exp) begin
            err_count++;
            $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    // One host write, strobe held for one rising edge
    task automatic host_write(logic [7:0] a, logic [15:0] d);
        @(negedge clk);
        host_wr   = 1'b1;
        host_addr = a;
        host_data = d;
        @(negedge clk);
        host_wr   = 1'b0;
    endtask

    // Verdict and end of run
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog, almost three times the expected run
    initial begin
        #(80000 * 50);
        err_count++;
        $display("MISMATCH watchdog expected finish seen hang");
        give_verdict();
    end

    // Main sequence
    initial begin
        int          cf;
        int          c0;
        int          n;
        int          sum;
        logic [15:0] msk;
        logic [15:0] exp;
        rows = '{
            '{8'h04, 5, 0, 8'h1A, 0},
            '{8'h41, 1, 1, 8'h01, 9},
            '{8'h11, 2, 0, 8'h03, 0},
            '{8'h41, 1, 1, 8'h00, 0},
            '{8'h05, 8, 0, 8'hF7, 11},
            '{8'h11, 2, 0, 8'h00, 0},
            '{8'h05, 2, 3, 8'h00, 0},
            '{8'h05, 2, 1, 8'h01, 0},
            '{8'h04, 1, 0, 8'h01, 0},
            '{8'h0E, 2, 0, 8'h03, 0},
            '{8'h0D, 2, 0, 8'h03, 0},
            '{8'h0F, 2, 0, 8'h03, 0},
            '{8'h16, 1, 1, 8'h01, 0},
            '{8'h12, 2, 2, 8'h03, 5},
            '{8'hFF, 1, 0, 8'h00, 0},
            '{8'h04, 1, 4, 8'h00, 0},
            '{8'h62, 1, 0, 8'h01, 6},
            '{8'hFF, 1, 0, 8'h00, 0},
            '{8'h5A, 8, 0, 8'h11, 0},
            '{8'h5E, 8, 0, 8'h11, 0},
            '{8'h5A, 8, 0, 8'h33, 0},
            '{8'h5E, 8, 0, 8'h33, 0},
            '{8'h45, 2, 0, 8'h02, 0},
            '{8'h43, 4, 0, 8'h0F, 12},
            '{8'h43, 4, 0, 8'h0F, 7},
            '{8'hFF, 1, 0, 8'h00, 0},
            '{8'h5A, 8, 0, 8'h77, 0},
            '{8'h5E, 8, 0, 8'h77, 0},
            '{8'h5A, 8, 0, 8'hFF, 0},
            '{8'h5E, 8, 0, 8'hFF, 0}};
        for (int i = 0; i < 256; i++) shadow[i] = {8'(i), 8'(i) ^ 8'hA5};
        err_count = 0;
        comparisons = 0;
        cyc = 0;
        rst = 1'b1;
        host_wr = 1'b0;
        host_addr = 8'h00;
        host_data = 16'h0000;
        // Reset held for ten cycles, outputs quiet meanwhile
        repeat (10) @(negedge clk);
        chk_bit("busy in reset", 1'b0, busy);
        chk_word("step in reset", 16'h0000, {11'h000, step});
        rst = 1'b0;
        $display("test reset done");
        // Near-miss launches are ignored
        host_write(8'h6E, 16'h0100);
        host_write(8'h6F, 16'h0120);
        repeat (3) @(negedge clk);
        chk_bit("busy after bad launch", 1'b0, busy);
        chk_bit("read after bad launch", 1'b0, reg_rd);
        $display("test refused launch done");
        // Full default program, step by step
        host_write(8'h6F, 16'h0100);
        c0 = cyc;
        sum = 0;
        for (int i = 0; i < 30; i++) begin
            n = 0;
            while (step !== 5'(i) && n < 20) begin
                @(negedge clk);
                n++;
            end
            chk_word("step index", 16'(i), {11'h000, step});
            cf = cyc;
            @(negedge clk);
            msk = 16'(((1 << rows[i].w) - 1) << rows[i].lsb);
            exp = (shadow[rows[i].addr] & ~msk)
                | (16'(rows[i].data) << rows[i].lsb & msk);
            chk_word("target address", 16'(rows[i].addr), 16'(reg_addr));
            chk_bit("read strobe", rows[i].addr != 8'hFF, reg_rd);
            @(negedge clk);
            chk_bit("write strobe", rows[i].addr != 8'hFF, reg_wr);
            if (rows[i].addr != 8'hFF) begin
                chk_word("merged write", exp, reg_wdata);
                shadow[rows[i].addr] = exp;
            end
            if (i == 5) host_write(8'h6F, 16'h0100);
            n = 0;
            while (step === 5'(i) && busy === 1'b1 && n < 20000) begin
                @(negedge clk);
                n++;
            end
            chk_count("step length", TICK * ((1 << rows[i].dly) + 8),
                      cyc - cf);
            sum += TICK * ((1 << rows[i].dly) + 8);
        end
        chk_bit("busy at end", 1'b0, busy);
        chk_bit("done at end", 1'b1, done);
        chk_count("program length", sum, cyc - c0);
        @(negedge clk);
        chk_bit("done pulse", 1'b0, done);
        chk_word("step held", 16'h001D, {11'h000, step});
        $display("test default program done");
        // Relaunch right away, then reset in mid-run
        host_write(8'h6F, 16'h0100);
        chk_bit("busy on relaunch", 1'b1, busy);
        chk_word("step on relaunch", 16'h0000, {11'h000, step});
        repeat (3) @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        chk_bit("busy after reset", 1'b0, busy);
        chk_bit("write after reset", 1'b0, reg_wr);
        chk_word("step after reset", 16'h0000, {11'h000, step});
        rst = 1'b0;
        repeat (3) @(negedge clk);
        chk_bit("busy stays low", 1'b0, busy);
        chk_bit("read stays low", 1'b0, reg_rd);
        $display("test relaunch and reset done");
        give_verdict();
    end
endmodule
